// File: design/pmcc_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the clock control block.
  Assumes byte offsets on 8 address bits and 32-bit register data.
*/
`ifndef PMCC_MAP_SVH
`define PMCC_MAP_SVH
`define PMCC_SCER 8'h00
`define PMCC_SCDR 8'h04
`define PMCC_SCSR 8'h08
`define PMCC_PCER 8'h10
`define PMCC_PCDR 8'h14
`define PMCC_PCSR 8'h18
`define PMCC_MOR 8'h20
`define PMCC_MCFR 8'h24
`define PMCC_PLLAR 8'h28
`define PMCC_PLLBR 8'h2c
`define PMCC_MCKR 8'h30
`define PMCC_SR 8'h68
`define PMCC_DEV_LAST 8'h6c
`define PMCC_CTL_STAT 8'h80
`define PMCC_SC_CPU 0
`define PMCC_SC_USB_DEV 1
`define PMCC_SC_SUSP_GATE 2
`define PMCC_SC_USB_HOST 4
`define PMCC_SCSR_RST 32'h0000_0001
`define PMCC_MOR_EN 0
`define PMCC_MOR_MASK 32'h0000_ff01
`define PMCC_PLL_RST 32'h0000_3f00
`define PMCC_PLL_MASK 32'h07ff_3fff
`define PMCC_PLLB_MASK 32'h17ff_3fff
`define PMCC_PLLB_HALF 28
`define PMCC_MCKR_MASK 32'h0000_031f
`define PMCC_MCKR_RST 32'h0000_0000
`define PMCC_PERIPH_MASK 32'hffff_fffc
`define PMCC_SR_OSC_STABLE 0
`define PMCC_SR_LOCK_A 1
`define PMCC_SR_LOCK_B 2
`define PMCC_SR_MCLK_RDY 3
`define PMCC_MCFR_RDY 16
`define PMCC_OSC_PRESCALE 3'h7
`define PMCC_FREQ_LAST_FALL 4'hf
`define PMCC_MCLK_SWITCH_SLOW 8'h04
`endif

// File: design/pmcc_pkg.sv
/*
  Types shared by the clock control ends.
  Assumes the map header supplies all numeric constants.
*/
package pmcc_pkg;
  typedef enum logic [1:0] {FQ_IDLE, FQ_WAIT_RISE, FQ_COUNT, FQ_DONE} pmcc_freq_st_t;
  typedef enum logic [1:0] {SRC_SLOW, SRC_MAIN, SRC_PLLA, SRC_PLLB} pmcc_src_t;
endpackage : pmcc_pkg

// File: design/pmcc_if.sv
/*
  Register access channel between the APB controller and the clock control device.
  Assumes one request at a time; the device answers with a one-cycle ack.
*/
`timescale 1ns/10ps
interface pmcc_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic err;
  modport dev (input req, we, addr, wdata, output rdata, ack, err);
  modport ctl (output req, we, addr, wdata, input rdata, ack, err);
endinterface : pmcc_if

// File: design/pmcc_countdown.sv
/*
  Loadable down counter with a done flag, used for startup, lock and switch waits.
  Assumes tick_i is a one-cycle pulse on the reference clock.
*/
`timescale 1ns/10ps
module pmcc_countdown (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic load_i,
  input wire logic stop_i,
  input wire logic [7:0] load_val_i,
  input wire logic tick_i,
  // Status
  output logic done_o
);
  logic [7:0] cnt_q;
  logic busy_q;
  wire at_zero = (cnt_q == 8'h00);

  // A reload restarts the wait and drops done in the same edge
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else if (stop_i) begin
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_q <= load_val_i;
      busy_q <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_q && at_zero) begin
      busy_q <= 1'b0;
      done_o <= 1'b1;
    end else if (busy_q && tick_i) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : pmcc_countdown

// File: design/pmcc_clock_ctrl.sv
/*
  Clock control device: oscillator startup, frequency meter, PLL lock, master select and clock gates.
  Assumes slow and main clocks arrive as pins, sampled here; main clock must stay below 10 MHz to be counted.
*/
// Added by the designer: the register channel port and the address map.
`timescale 1ns/10ps
`include "pmcc_map.svh"
module pmcc_clock_ctrl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Register channel
  pmcc_if.dev bus,
  // Clock pins
  input wire logic slow_clk_pin_i,
  input wire logic main_clk_pin_i,
  // System events
  input wire logic irq_wake_i,
  input wire logic fiq_wake_i,
  input wire logic cpu_instr_done_i,
  input wire logic usb_suspend_i,
  // Oscillator and PLL controls
  output logic osc_enable_o,
  output logic osc_pin_hold_low_o,
  output logic div_a_run_o,
  output logic div_b_run_o,
  output logic pll_a_on_o,
  output logic pll_b_on_o,
  output logic [7:0] div_a_o,
  output logic [7:0] div_b_o,
  output logic [10:0] mul_a_o,
  output logic [10:0] mul_b_o,
  output logic pll_b_half_o,
  // Master clock selection
  output logic [1:0] mclk_src_o,
  output logic [2:0] mclk_prescale_o,
  output logic [1:0] mclk_div_o,
  // Clock gates
  output logic cpu_clk_en_o,
  output logic [31:0] periph_clk_en_o,
  output logic usb_dev_clk_en_o,
  output logic usb_host_clk_en_o,
  output logic usb_dev_mclk_en_o
);
  function automatic logic pll_runs(input logic [31:0] r);
    pll_runs = (r[26:16] != 11'h000) && (r[7:0] != 8'h00);
  endfunction : pll_runs

  logic slow_meta_q, slow_q, slow_d1_q, main_meta_q, main_q, main_d1_q;
  logic [31:0] mor_q, plla_q, pllb_q, mckr_q, pcsr_q, rdata_q;
  logic cpu_en_q, stop_pend_q, usb_dev_q, susp_gate_q, usb_host_q, susp_q, mclk_gate_q, ack_q, err_q;
  logic [2:0] pre8_q;
  logic [15:0] fcnt_q;
  logic [3:0] falls_q;
  logic fq_rdy_q;
  pmcc_pkg::pmcc_freq_st_t fst_q, fst_d;
  logic osc_stable, lock_a, lock_b, mclk_wait_done;

  // Pins are asynchronous to the reference clock
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {slow_meta_q, slow_q, slow_d1_q} <= 3'h0;
      {main_meta_q, main_q, main_d1_q} <= 3'h0;
    end else begin
      {slow_meta_q, slow_q, slow_d1_q} <= {slow_clk_pin_i, slow_meta_q, slow_q};
      {main_meta_q, main_q, main_d1_q} <= {main_clk_pin_i, main_meta_q, main_q};
    end
  end
  wire slow_rise = slow_q & ~slow_d1_q;
  wire slow_fall = ~slow_q & slow_d1_q;
  wire main_rise = main_q & ~main_d1_q;

  wire take = bus.req & ~ack_q;
  wire wr = take & bus.we;
  wire wr_scer = wr && (bus.addr == `PMCC_SCER);
  wire wr_scdr = wr && (bus.addr == `PMCC_SCDR);
  wire wr_pcer = wr && (bus.addr == `PMCC_PCER);
  wire wr_pcdr = wr && (bus.addr == `PMCC_PCDR);
  wire wr_mor = wr && (bus.addr == `PMCC_MOR);
  wire wr_plla = wr && (bus.addr == `PMCC_PLLAR);
  wire wr_pllb = wr && (bus.addr == `PMCC_PLLBR);
  wire wr_mckr = wr && (bus.addr == `PMCC_MCKR);
  wire [31:0] mor_new = bus.wdata & `PMCC_MOR_MASK;
  wire [31:0] plla_new = bus.wdata & `PMCC_PLL_MASK;
  wire [31:0] pllb_new = bus.wdata & `PMCC_PLLB_MASK;
  wire osc_start = wr_mor & mor_new[`PMCC_MOR_EN];
  wire osc_stop = wr_mor & ~mor_new[`PMCC_MOR_EN];
  wire plla_chg = wr_plla && (plla_new != plla_q);
  wire pllb_chg = wr_pllb && (pllb_new != pllb_q);
  wire [31:0] sc_set = wr_scer ? bus.wdata : 32'h0000_0000;
  wire [31:0] sc_clr = wr_scdr ? bus.wdata : 32'h0000_0000;
  wire susp_rise = usb_suspend_i & ~susp_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mor_q <= 32'h0000_0000;
      plla_q <= `PMCC_PLL_RST;
      pllb_q <= `PMCC_PLL_RST;
      mckr_q <= `PMCC_MCKR_RST;
      pcsr_q <= 32'h0000_0000;
    end else begin
      if (wr_mor) mor_q <= mor_new;
      if (wr_plla) plla_q <= plla_new;
      if (wr_pllb) pllb_q <= pllb_new;
      if (wr_mckr) mckr_q <= bus.wdata & `PMCC_MCKR_MASK;
      pcsr_q <= ((pcsr_q & ~(wr_pcdr ? bus.wdata : 32'h0)) | (wr_pcer ? bus.wdata : 32'h0)) & `PMCC_PERIPH_MASK;
    end
  end

  // Oscillator startup counts on slow clock divided by eight
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) pre8_q <= 3'h0;
    else if (osc_start) pre8_q <= 3'h0;
    else if (slow_rise) pre8_q <= pre8_q + 3'h1;
  end
  wire osc_tick = slow_rise && (pre8_q == `PMCC_OSC_PRESCALE);

  pmcc_countdown u_osc (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .load_i(osc_start), .stop_i(osc_stop),
    .load_val_i(mor_new[15:8]), .tick_i(osc_tick), .done_o(osc_stable));
  pmcc_countdown u_lock_a (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .load_i(plla_chg & pll_runs(plla_new)), .stop_i(plla_chg & ~pll_runs(plla_new)),
    .load_val_i({2'b00, plla_new[13:8]}), .tick_i(slow_rise), .done_o(lock_a));
  pmcc_countdown u_lock_b (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .load_i(pllb_chg & pll_runs(pllb_new)), .stop_i(pllb_chg & ~pll_runs(pllb_new)),
    .load_val_i({2'b00, pllb_new[13:8]}), .tick_i(slow_rise), .done_o(lock_b));
  pmcc_countdown u_mclk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .load_i(wr_mckr), .stop_i(1'b0),
    .load_val_i(`PMCC_MCLK_SWITCH_SLOW), .tick_i(slow_rise), .done_o(mclk_wait_done));

  // A PLL source is only established once that PLL has locked
  wire src_ok = (mckr_q[1:0] == pmcc_pkg::SRC_SLOW) ? 1'b1 :
                (mckr_q[1:0] == pmcc_pkg::SRC_MAIN) ? osc_stable :
                (mckr_q[1:0] == pmcc_pkg::SRC_PLLA) ? lock_a : lock_b;
  wire mclk_rdy = mclk_wait_done & src_ok;

  always_comb begin
    fst_d = fst_q;
    case (fst_q)
      pmcc_pkg::FQ_IDLE: if (osc_stable) fst_d = pmcc_pkg::FQ_WAIT_RISE;
      pmcc_pkg::FQ_WAIT_RISE: if (slow_rise) fst_d = pmcc_pkg::FQ_COUNT;
      pmcc_pkg::FQ_COUNT: if (slow_fall && falls_q == `PMCC_FREQ_LAST_FALL) fst_d = pmcc_pkg::FQ_DONE;
      pmcc_pkg::FQ_DONE: fst_d = pmcc_pkg::FQ_DONE;
      default: fst_d = pmcc_pkg::FQ_IDLE;
    endcase
    if (!osc_stable) fst_d = pmcc_pkg::FQ_IDLE;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fst_q <= pmcc_pkg::FQ_IDLE;
      fcnt_q <= 16'h0000;
      falls_q <= 4'h0;
      fq_rdy_q <= 1'b0;
    end else begin
      fst_q <= fst_d;
      fq_rdy_q <= (fst_d == pmcc_pkg::FQ_DONE);
      if (fst_q == pmcc_pkg::FQ_WAIT_RISE) begin
        fcnt_q <= 16'h0000;
        falls_q <= 4'h0;
      end else if (fst_q == pmcc_pkg::FQ_COUNT) begin
        if (main_rise) fcnt_q <= fcnt_q + 16'h0001;
        if (slow_fall) falls_q <= falls_q + 4'h1;
      end
    end
  end

  // Wake beats a pending stop; the stop waits for the instruction to end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cpu_en_q <= 1'b1;
      stop_pend_q <= 1'b0;
    end else if (irq_wake_i | fiq_wake_i | sc_set[`PMCC_SC_CPU]) begin
      cpu_en_q <= 1'b1;
      stop_pend_q <= 1'b0;
    end else if ((stop_pend_q | sc_clr[`PMCC_SC_CPU]) & cpu_instr_done_i) begin
      cpu_en_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else if (sc_clr[`PMCC_SC_CPU]) begin
      stop_pend_q <= 1'b1;
    end
  end

  // Software enable wins over a suspend arriving in the same cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {usb_dev_q, susp_gate_q, usb_host_q, susp_q, mclk_gate_q} <= 5'h00;
    end else begin
      susp_q <= usb_suspend_i;
      usb_dev_q <= sc_set[`PMCC_SC_USB_DEV] | (usb_dev_q & ~sc_clr[`PMCC_SC_USB_DEV] & ~susp_rise);
      susp_gate_q <= sc_set[`PMCC_SC_SUSP_GATE] | (susp_gate_q & ~sc_clr[`PMCC_SC_SUSP_GATE]);
      usb_host_q <= sc_set[`PMCC_SC_USB_HOST] | (usb_host_q & ~sc_clr[`PMCC_SC_USB_HOST]);
      mclk_gate_q <= susp_gate_q & usb_suspend_i;
    end
  end

  wire [31:0] scsr = {27'h0, usb_host_q, 1'b0, susp_gate_q, usb_dev_q, cpu_en_q};
  wire [31:0] mcfr = {15'h0, fq_rdy_q, fcnt_q};
  wire [31:0] sr = {28'h0, mclk_rdy, lock_b, lock_a, osc_stable};
  wire known = (bus.addr == `PMCC_SCER) | (bus.addr == `PMCC_SCDR) | (bus.addr == `PMCC_SCSR) |
               (bus.addr == `PMCC_PCER) | (bus.addr == `PMCC_PCDR) | (bus.addr == `PMCC_PCSR) |
               (bus.addr == `PMCC_MOR) | (bus.addr == `PMCC_MCFR) | (bus.addr == `PMCC_PLLAR) |
               (bus.addr == `PMCC_PLLBR) | (bus.addr == `PMCC_MCKR) | (bus.addr == `PMCC_SR);
  wire [31:0] rd_val = (bus.addr == `PMCC_SCSR) ? scsr :
                       (bus.addr == `PMCC_PCSR) ? pcsr_q :
                       (bus.addr == `PMCC_MOR) ? mor_q :
                       (bus.addr == `PMCC_MCFR) ? mcfr :
                       (bus.addr == `PMCC_PLLAR) ? plla_q :
                       (bus.addr == `PMCC_PLLBR) ? pllb_q :
                       (bus.addr == `PMCC_MCKR) ? mckr_q :
                       (bus.addr == `PMCC_SR) ? sr : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      err_q <= take & ~known;
      if (take) rdata_q <= bus.we ? 32'h0000_0000 : rd_val;
    end
  end

  assign bus.ack = ack_q;
  assign bus.err = err_q;
  assign bus.rdata = rdata_q;
  assign osc_enable_o = mor_q[`PMCC_MOR_EN];
  assign osc_pin_hold_low_o = ~mor_q[`PMCC_MOR_EN];
  assign div_a_o = plla_q[7:0];
  assign div_b_o = pllb_q[7:0];
  assign mul_a_o = plla_q[26:16];
  assign mul_b_o = pllb_q[26:16];
  assign div_a_run_o = (plla_q[7:0] != 8'h00);
  assign div_b_run_o = (pllb_q[7:0] != 8'h00);
  assign pll_a_on_o = pll_runs(plla_q);
  assign pll_b_on_o = pll_runs(pllb_q);
  assign pll_b_half_o = pllb_q[`PMCC_PLLB_HALF];
  assign mclk_src_o = mckr_q[1:0];
  assign mclk_prescale_o = mckr_q[4:2];
  assign mclk_div_o = mckr_q[9:8];
  assign cpu_clk_en_o = cpu_en_q;
  assign periph_clk_en_o = pcsr_q;
  assign usb_dev_clk_en_o = usb_dev_q;
  assign usb_host_clk_en_o = usb_host_q;
  assign usb_dev_mclk_en_o = ~mclk_gate_q;
endmodule : pmcc_clock_ctrl

// File: design/pmcc_apb_ctrl.sv
/*
  APB slave that carries software register accesses to the clock control device.
  Assumes an APB master on ref_clk_i and the device end on the channel interface.
*/
`timescale 1ns/10ps
`include "pmcc_map.svh"
module pmcc_apb_ctrl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Device channel
  pmcc_if.ctl bus
);
  logic own_ack_q, own_err_q, err_sticky_q;
  logic [31:0] own_rd_q;

  wire access = psel_i & penable_i;
  wire to_dev = (paddr_i[31:8] == 24'h0) && (paddr_i[7:0] <= `PMCC_DEV_LAST) && (paddr_i[1:0] == 2'b00);
  wire is_stat = (paddr_i == {24'h0, `PMCC_CTL_STAT});
  wire local_take = access & ~to_dev & ~own_ack_q;
  wire stat_clr = local_take & is_stat & pwrite_i & pwdata_i[0];
  wire err_evt = (bus.ack & bus.err) | (local_take & ~is_stat);

  // Device request holds for the whole access phase; the device acks once
  assign bus.req = access & to_dev;
  assign bus.we = pwrite_i;
  assign bus.addr = paddr_i[7:0];
  assign bus.wdata = pwdata_i;

  // A new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      own_ack_q <= 1'b0;
      own_err_q <= 1'b0;
      own_rd_q <= 32'h0000_0000;
      err_sticky_q <= 1'b0;
    end else begin
      own_ack_q <= local_take;
      own_err_q <= local_take & ~is_stat;
      if (local_take) own_rd_q <= (is_stat & ~pwrite_i) ? {31'h0, err_sticky_q} : 32'h0000_0000;
      err_sticky_q <= err_evt | (err_sticky_q & ~stat_clr);
    end
  end

  assign pready_o = to_dev ? bus.ack : own_ack_q;
  assign pslverr_o = to_dev ? (bus.ack & bus.err) : own_err_q;
  assign prdata_o = to_dev ? bus.rdata : own_rd_q;
endmodule : pmcc_apb_ctrl

// File: verif/pmcc_clock_ctrl_asserts.sv
/*
  Checker on the register channel and the oscillator and PLL A outputs.
  Assumes the bench top instantiates it beside the channel interface.
*/
`timescale 1ns/10ps
module pmcc_clock_ctrl_asserts (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Channel
  input wire logic req,
  input wire logic ack,
  input wire logic err,
  // Device outputs
  input wire logic osc_enable_o,
  input wire logic osc_pin_hold_low_o,
  input wire logic div_a_run_o,
  input wire logic pll_a_on_o,
  input wire logic [7:0] div_a_o,
  input wire logic [10:0] mul_a_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_pulse;
    ack ##1 !ack;
  endsequence
  a_ack_next_pulse: assert property (s_take |=> s_pulse) else $error("channel ack not a next-cycle pulse");
  a_ack_has_cause: assert property ($rose(ack) |-> $past(req)) else $error("ack without request");
  a_err_with_ack: assert property (err |-> ack) else $error("err without ack");
  a_pin_held_low: assert property (osc_pin_hold_low_o == !osc_enable_o) else $error("pin hold wrong");
  a_pin_low_off: assert property ($fell(osc_enable_o) |-> osc_pin_hold_low_o) else $error("pin not held");
  a_div_run_match: assert property (div_a_run_o == (div_a_o != 8'h00)) else $error("divider run wrong");
  a_div_zero_off: assert property (div_a_o == 8'h00 |-> !pll_a_on_o) else $error("pll on with zero divider");
  a_pll_mul_on: assert property (pll_a_on_o == (mul_a_o != 11'h000 && div_a_o != 8'h00))
    else $error("pll enable wrong");
  // Multiplier changes only follow a raised channel request
  a_mul_held: assert property (!$past(req) |-> $stable(mul_a_o)) else $error("multiplier moved");
endmodule : pmcc_clock_ctrl_asserts

// File: verif/pmcc_clock_ctrl_tb.sv
/*
  Bench joining the APB controller and the clock device over the channel.
  Assumes pin clocks far slower than ref_clk_i, so sampled counts hold.
*/
`timescale 1ns/10ps
`include "pmcc_map.svh"
module pmcc_clock_ctrl_tb;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic slow_pin = 1'b0, main_pin = 1'b0, irq = 1'b0, fiq = 1'b0, done = 1'b1, suspend = 1'b0;
  logic osc_en, hold_low, a_run, b_run, a_on, b_on, half, cpu_en, udev, uhost, umclk;
  logic [7:0] div_a, div_b;
  logic [10:0] mul_a, mul_b;
  logic [1:0] src, mclk_div;
  logic [2:0] prescale;
  logic [31:0] periph;
  logic [3:0] ph = 4'h0;
  int cyc = 0;
  int err_count = 0;
  int compares = 0;
  pmcc_if bus_if ();
  pmcc_apb_ctrl pmcc_apb_ctrl_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus(bus_if.ctl));
  pmcc_clock_ctrl pmcc_clock_ctrl_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .bus(bus_if.dev),
    .slow_clk_pin_i(slow_pin), .main_clk_pin_i(main_pin), .irq_wake_i(irq), .fiq_wake_i(fiq),
    .cpu_instr_done_i(done), .usb_suspend_i(suspend), .osc_enable_o(osc_en), .osc_pin_hold_low_o(hold_low),
    .div_a_run_o(a_run), .div_b_run_o(b_run), .pll_a_on_o(a_on), .pll_b_on_o(b_on), .div_a_o(div_a),
    .div_b_o(div_b), .mul_a_o(mul_a), .mul_b_o(mul_b), .pll_b_half_o(half), .mclk_src_o(src),
    .mclk_prescale_o(prescale), .mclk_div_o(mclk_div), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(periph),
    .usb_dev_clk_en_o(udev), .usb_host_clk_en_o(uhost), .usb_dev_mclk_en_o(umclk));
  pmcc_clock_ctrl_asserts pmcc_clock_ctrl_asserts_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .req(bus_if.req), .ack(bus_if.ack), .err(bus_if.err), .osc_enable_o(osc_en), .osc_pin_hold_low_o(hold_low),
    .div_a_run_o(a_run), .pll_a_on_o(a_on), .div_a_o(div_a), .mul_a_o(mul_a));
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Slow pin period 16 cycles, main pin period 4 cycles
  always @(posedge ref_clk_i) begin
    ph <= ph + 4'h1;
    cyc <= cyc + 1;
    if (ph[2:0] == 3'h7) slow_pin <= ~slow_pin;
    if (ph[0]) main_pin <= ~main_pin;
  end
  task automatic stop_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic ee = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("wr_err", {31'h0, ee}, {31'h0, e});
  endtask : wr
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] x, input logic [31:0] m = '1,
                    input logic ee = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r & m);
    chk("rd_err", {31'h0, ee}, {31'h0, e});
  endtask : rd
  task automatic wait_bit(input logic [31:0] a, input int b, output logic [31:0] r);
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0, r, e);
      n++;
    end while (r[b] !== 1'b1 && n < 300);
    if (r[b] !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask : wait_bit
  initial begin
    logic [31:0] r;
    int t0;
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rd("scsr", `PMCC_SCSR, 32'h1);
    rd("pcsr", `PMCC_PCSR, 32'h0);
    rd("mor", `PMCC_MOR, 32'h0);
    rd("pllar", `PMCC_PLLAR, 32'h3f00);
    rd("pllbr", `PMCC_PLLBR, 32'h3f00);
    rd("mckr", `PMCC_MCKR, 32'h0);
    chk("rst_out", 32'h4, {29'h0, hold_low, a_run, b_run});
    wr(`PMCC_PCER, 32'hffff_ffff);
    chk("periph", 32'hffff_fffc, periph);
    rd("pcsr", `PMCC_PCSR, 32'hffff_fffc);
    wr(`PMCC_PCDR, 32'h0000_0010);
    chk("periph", 32'hffff_ffec, periph);
    wr(`PMCC_SCER, 32'h16);
    rd("scsr", `PMCC_SCSR, 32'h17);
    chk("usb_on", 32'h3, {30'h0, udev, uhost});
    suspend <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk("usb_sus", 32'h1, {30'h0, udev, uhost} & {30'h0, 1'b1, ~umclk});
    rd("scsr", `PMCC_SCSR, 32'h15);
    suspend <= 1'b0;
    wr(`PMCC_SCDR, 32'h14);
    rd("scsr", `PMCC_SCSR, 32'h1);
    done <= 1'b0;
    wr(`PMCC_SCDR, 32'h1);
    chk("cpu_busy", 32'h1, {31'h0, cpu_en});
    done <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(`PMCC_SCDR, 32'h1);
      rd("cpu_idle", `PMCC_SCSR, 32'h0);
      {irq, fiq} <= (k == 0) ? 2'b10 : 2'b01;
      repeat (3) @(posedge ref_clk_i);
      chk("cpu_wake", 32'h1, {31'h0, cpu_en});
      {irq, fiq} <= 2'b00;
    end
    t0 = cyc;
    wr(`PMCC_MOR, 32'h0000_0201);
    chk("osc_on", 32'h2, {30'h0, osc_en, hold_low});
    rd("stable", `PMCC_SR, 32'h0, 32'h1);
    rd("f_rdy", `PMCC_MCFR, 32'h0, 32'h1_0000);
    wait_bit(`PMCC_SR, `PMCC_SR_OSC_STABLE, r);
    chk("osc_wait", 32'h1, {31'h0, (cyc - t0) >= 240});
    wait_bit(`PMCC_MCFR, `PMCC_MCFR_RDY, r);
    // Sampled counting may lose a main edge at each end of the window
    chk("main_freq_count", 32'h1, {31'h0, r[15:0] >= 16'd60 && r[15:0] <= 16'd66});
    t0 = cyc;
    wr(`PMCC_PLLAR, 32'h0005_0302);
    chk("pll_a", 32'h0000_4017, {11'h0, div_a, mul_a, a_on, a_run});
    rd("lock_a", `PMCC_SR, 32'h0, 32'h2);
    wait_bit(`PMCC_SR, `PMCC_SR_LOCK_A, r);
    chk("lock_wait", 32'h1, {31'h0, (cyc - t0) >= 32});
    wr(`PMCC_PLLAR, 32'h0000_0302);
    chk("mul_off", 32'h1, {30'h0, a_on, a_run});
    rd("lock_off", `PMCC_SR, 32'h0, 32'h2);
    wr(`PMCC_PLLAR, 32'h0005_0300);
    chk("div_zero", 32'h0, {30'h0, a_on, a_run});
    wr(`PMCC_PLLBR, 32'h1005_0302);
    chk("pll_b", 32'h0004_0817, {13'h0, half, div_b, mul_b[7:0], b_on, b_run});
    rd("pllbr", `PMCC_PLLBR, 32'h1005_0302);
    wr(`PMCC_MCKR, 32'h0000_0109);
    chk("mclk_sel", 32'h29, {25'h0, src, prescale, mclk_div});
    rd("mclk_rdy", `PMCC_SR, 32'h0, 32'h8);
    wait_bit(`PMCC_SR, `PMCC_SR_MCLK_RDY, r);
    rd("mckr", `PMCC_MCKR, 32'h109);
    rd("resv", 32'h0c, 32'h0, '1, 1'b1);
    rd("far", 32'h70, 32'h0, '1, 1'b1);
    rd("sticky", `PMCC_CTL_STAT, 32'h1, 32'h1);
    wr(`PMCC_CTL_STAT, 32'h1);
    rd("sticky", `PMCC_CTL_STAT, 32'h0, 32'h1);
    stop_test();
  end
endmodule : pmcc_clock_ctrl_tb
